// [verilog/sram_port_defs.vh]
/*
 * Constants for the pipelined burst static memory port: widths, burst
 * length, mode codes and reset values.
 * Assumes inclusion by bare name from the design files under verilog/.
 */
// Notes on behaviour
// - Address captured on edge selects one location
// - Active-low lane selects write only with strobe
// - Write strobe low starts write, qualified edges
// - Advance high steps the burst counter
// - Advance low loads a fresh address
// - Synchronous inputs captured only when clock-qualify low
// - Three chip selects, two low one high
// - Output enable low drives, high tristates
// - Outputs off on write data, first select, deselect; code still drives a prior read's data during the first write beat
// - Clock-qualify high freezes state, no deselect
// - Strap high interleaved, low linear, static
// - Read data returns one edge after address
// - Parity lines follow their byte lane selects
`ifndef SRAM_PORT_DEFS_VH
`define SRAM_PORT_DEFS_VH

`define SRAM_ADDR_W      10
`define SRAM_LANES       4
`define SRAM_BURST_W     2
`define SRAM_ORDER_LIN   1'b0
`define SRAM_ORDER_ILV   1'b1
`define SRAM_RST_ADDR    10'h000
`define SRAM_RST_BURST   2'h0
`define SRAM_STRAP_WAIT  2'h2

`endif

// [verilog/burst_step.v]
/*
 * Burst address stepper: gives the next low address bits of a burst
 * in linear or interleaved order.
 * Assumes the caller holds the start offset and current count.
 */
`default_nettype none

module burst_step #(
    parameter BW = 2
) (
    // Burst state
    input  wire [BW-1:0] i_start,
    input  wire [BW-1:0] i_count,
    input  wire          i_interleave,
    // Result
    output wire [BW-1:0] o_next_count,
    output wire [BW-1:0] o_low_addr
);
    // Count steps by one; order maps it onto the address
    assign o_next_count = i_count + {{(BW-1){1'b0}}, 1'b1};
    assign o_low_addr   = i_interleave ? (i_start ^ o_next_count)
                                       : (i_start + o_next_count);
endmodule // burst_step

`default_nettype wire

// [verilog/sync_pipelined_sram_port.v]
/*
 * Pipelined burst static memory: synchronous control, burst counter,
 * pipelined read return and output-enable gating of the data pins.
 * Assumes all control inputs are synchronous to i_clock from a
 * controller on the same clock; i_burst_mode and i_oe_n are pins.
 */
`include "sram_port_defs.vh"
`default_nettype none

module sync_pipelined_sram_port #(
    parameter AW  = `SRAM_ADDR_W,
    parameter NL  = `SRAM_LANES,
    parameter BW  = `SRAM_BURST_W
) (
    // Clock and reset
    input  wire               i_clock,
    input  wire               i_rst_n,
    // Address and control
    input  wire [AW-1:0]      i_addr,
    input  wire [NL-1:0]      i_byte_lane_write_n,
    input  wire               i_write_n,
    input  wire               i_advance_or_load,
    input  wire               i_clock_qualify_n,
    input  wire               i_select_low_first,
    input  wire               i_select_high,
    input  wire               i_select_low_third,
    input  wire               i_oe_n,
    input  wire               i_burst_mode,
    // Data and parity pins split into inputs, outputs and one drive enable
    input  wire [NL*8-1:0]    i_data,
    input  wire [NL-1:0]      i_parity_lines,
    output reg  [NL*8-1:0]    o_data,
    output reg  [NL-1:0]      o_parity_lines,
    output reg                o_data_oe
);
    localparam DEPTH = 1 << AW;

    // Storage, nine bits per lane
    reg [8:0] mem [0:DEPTH*NL-1];

    // Pin synchronisers for the asynchronous inputs
    reg oe_s1_q, oe_s2_q, mode_s1_q, mode_s2_q;

    // Pipeline state
    reg [AW-1:0] addr_q;
    reg [BW-1:0] start_q, count_q;
    reg          sel_q, was_sel_q, wr_q;
    reg [NL-1:0] lanes_q;
    reg          rd_pend_q;
    reg          order_q;
    reg [1:0]    order_wait_q;

    wire         edge_ok = ~i_clock_qualify_n;
    wire         sel_now = ~i_select_low_first & i_select_high
                           & ~i_select_low_third;
    wire [BW-1:0] nxt_cnt, nxt_low;
    wire [AW-1:0] acc_addr;
    // Read data may drive unless first cycle after deselect
    wire         read_live = sel_q & ~wr_q & was_sel_q;

    burst_step #(.BW(BW)) u_step (
        .i_start      (start_q),
        .i_count      (count_q),
        .i_interleave (order_q),
        .o_next_count (nxt_cnt),
        .o_low_addr   (nxt_low)
    );

    // Load takes the pins; advance steps the low bits
    assign acc_addr = i_advance_or_load ? {addr_q[AW-1:BW], nxt_low}
                                        : i_addr;

    // Two-flop synchronisers
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_s1_q   <= 1'b1;
            oe_s2_q   <= 1'b1;
            mode_s1_q <= 1'b1;
            mode_s2_q <= 1'b1;
        end else begin
            oe_s1_q   <= i_oe_n;
            oe_s2_q   <= oe_s1_q;
            mode_s1_q <= i_burst_mode;
            mode_s2_q <= mode_s1_q;
        end
    end

    // Strap caught once the synchroniser has filled, then held
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            order_q      <= `SRAM_ORDER_ILV;
            order_wait_q <= 2'h0;
        end else if (order_wait_q != 2'h3) begin
            if (order_wait_q == `SRAM_STRAP_WAIT) begin
                order_q <= mode_s2_q;
            end
            order_wait_q <= order_wait_q + 2'h1;
        end
    end

    // Command stage; unqualified edges hold everything
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_q    <= `SRAM_RST_ADDR;
            start_q   <= `SRAM_RST_BURST;
            count_q   <= `SRAM_RST_BURST;
            sel_q     <= 1'b0;
            was_sel_q <= 1'b0;
            wr_q      <= 1'b0;
            lanes_q   <= {NL{1'b0}};
            rd_pend_q <= 1'b0;
        end else if (edge_ok) begin
            was_sel_q <= sel_q;
            rd_pend_q <= read_live;
            if (i_advance_or_load) begin
                // Burst continues the prior access type
                addr_q  <= acc_addr;
                count_q <= nxt_cnt;
                lanes_q <= ~i_byte_lane_write_n;
            end else begin
                addr_q  <= i_addr;
                start_q <= i_addr[BW-1:0];
                count_q <= `SRAM_RST_BURST;
                sel_q   <= sel_now;
                wr_q    <= ~i_write_n;
                lanes_q <= ~i_byte_lane_write_n;
            end
        end
    end

    // Write data phase: lane selects gate bytes and parity
    integer k;
    integer j;
    always @(posedge i_clock) begin
        if (i_rst_n && edge_ok && sel_q && wr_q) begin
            for (k = 0; k < NL; k = k + 1) begin
                if (lanes_q[k]) begin
                    mem[addr_q*NL+k] <= {i_parity_lines[k], i_data[k*8 +: 8]};
                end
            end
        end
    end

    // Registered read return from the prior address
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data         <= {(NL*8){1'b0}};
            o_parity_lines <= {NL{1'b0}};
        end else if (edge_ok && sel_q && !wr_q) begin
            for (j = 0; j < NL; j = j + 1) begin
                o_data[j*8 +: 8]  <= mem[addr_q*NL+j][7:0];
                o_parity_lines[j] <= mem[addr_q*NL+j][8];
            end
        end
    end

    // Drive enable in step with read data; oe pin acts on any edge
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data_oe <= 1'b0;
        end else if (edge_ok) begin
            o_data_oe <= ~oe_s2_q & read_live;
        end else begin
            o_data_oe <= ~oe_s2_q & rd_pend_q;
        end
    end
endmodule // sync_pipelined_sram_port

`default_nettype wire

// [bench/sram_port_props.sv]
/* Port checker: oe masking and freeze. Bound from the test top. */
`default_nettype none
module sram_port_props (
    // Watched ports
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_write_n,
    input wire logic        i_advance_or_load,
    input wire logic        i_clock_qualify_n,
    input wire logic        i_select_low_first,
    input wire logic        i_select_high,
    input wire logic        i_select_low_third,
    input wire logic        i_oe_n,
    input wire logic [31:0] o_data,
    input wire logic        o_data_oe
);
    timeunit 1ns / 1ns;
    // Qualified edge, load, full selection
    wire q = !i_clock_qualify_n;
    wire ld = q && !i_advance_or_load;
    wire go = ld && !i_select_low_first && i_select_high && !i_select_low_third;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_freeze_holds: assert property (!q |=> $stable(o_data))
        else $error("frozen output moved");
    a_freeze_oe: assert property (!q && $past(i_oe_n, 2) == $past(i_oe_n, 3) |=> $stable(o_data_oe))
        else $error("frozen drive moved");
    a_first_off: assert property (ld && i_select_low_first ##1 q |=> !o_data_oe)
        else $error("deselected drive");
    a_third_off: assert property (ld && i_select_low_third ##1 q |=> !o_data_oe)
        else $error("deselected drive");
    a_high_off: assert property (ld && !i_select_high ##1 q |=> !o_data_oe)
        else $error("deselected drive");
    a_write_quiet: assert property (ld && !i_write_n ##1 q |=> !o_data_oe)
        else $error("write phase drive");
    a_first_masked: assert property (ld && !go ##1 go ##1 q |=> !o_data_oe)
        else $error("first cycle drive");
    a_oe_off: assert property ((i_oe_n && q) [*4] |-> !o_data_oe)
        else $error("drive with oe off");
    a_read_drives: assert property (go && !i_oe_n ##1 go && i_write_n ##1 q |=> o_data_oe)
        else $error("read not driven");
endmodule // sram_port_props
`default_nettype wire

// [bench/sram_ctrl_model.sv]
/* Controller model: pins follow commands. Fed by the test top. */
`default_nettype none
module sram_ctrl_model (
    input  wire logic        i_clock,
    input  wire logic [56:0] i_cmd,
    output wire logic [56:0] o_pins
);
    timeunit 1ns / 1ns;
    // Remembers whether the last qualified load deselected
    logic desel_q = 1'h1;
    always @(posedge i_clock) begin
        if (!o_pins[56] && !o_pins[54]) begin
            desel_q <= !(!o_pins[53] && o_pins[52] && !o_pins[51]);
        end
    end
    // After a deselect the next access loads a fresh address
    assign o_pins = {i_cmd[56:55], i_cmd[54] && !desel_q, i_cmd[53:0]};
endmodule // sram_ctrl_model
`default_nettype wire

// [bench/sync_pipelined_sram_port_test.sv]
/* Test top: random traffic checked against a behavioural memory. */
`default_nettype none
module sync_pipelined_sram_port_test;
    timeunit 1ns / 1ns;
    // Stimulus, pins and reference state
    logic        i_clock = 1'h0;
    logic        i_rst_n = 1'h0;
    logic        mode = 1'h0;
    logic        sw, sr;
    logic        o1, o2, ws, hold, exp_oe;
    wire         oe;
    logic [1:0]  cnt;
    logic [3:0]  ba, pa, pl;
    logic [31:0] r = 32'hcbab;
    logic [35:0] exp_q;
    logic [35:0] mem [0:15];
    logic [56:0] cmd = 57'h0;
    wire  [56:0] pins;
    wire  [31:0] d, rd;
    wire  [9:0]  a;
    wire  [3:0]  bw, dp, rp;
    wire         qn, wn, adv, s1, s2, s3, oen;
    int          miscompares = 0;
    int          comparisons = 0;
    assign {qn, wn, adv, s1, s2, s3, oen, bw, a, d, dp} = pins;
    sram_ctrl_model ctrl (.i_clock(i_clock), .i_cmd(cmd), .o_pins(pins));
    sync_pipelined_sram_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(a),
        .i_byte_lane_write_n(bw), .i_write_n(wn), .i_advance_or_load(adv),
        .i_clock_qualify_n(qn), .i_select_low_first(s1), .i_select_high(s2),
        .i_select_low_third(s3), .i_oe_n(oen), .i_burst_mode(mode), .i_data(d),
        .i_parity_lines(dp), .o_data(rd), .o_parity_lines(rp), .o_data_oe(oe));
    initial forever #20 i_clock = ~i_clock;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check_data(input logic [35:0] e);
        comparisons++;
        if ({rp, rd} !== e) begin
            miscompares++;
            $display("ERROR %0t data %h", $time, {rp, rd});
        end
    endtask
    task automatic check_oe(input logic e);
        comparisons++;
        if (oe !== e) begin
            miscompares++;
            $display("ERROR %0t drive enable %b", $time, oe);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reference: compare held read data, then apply the coming edge
    always @(negedge i_clock) begin
        if (i_rst_n !== 1'h1) begin
            exp_q = 36'h0;
            exp_oe = 1'h0;
            sw = 1'h0;
            sr = 1'h0;
            ws = 1'h0;
            hold = 1'h0;
            o1 = 1'h1;
            o2 = 1'h1;
        end else begin
            check_data(exp_q);
            check_oe(exp_oe);
            exp_oe = !o2; // Pin seen two edges late
            o2 = o1;
            o1 = oen;
            if (!qn) begin
                for (int k = 0; k < 4; k++)
                    if (sw && !pl[k]) {mem[pa][32+k], mem[pa][8*k+:8]} = {dp[k], d[8*k+:8]};
                if (sr) exp_q = mem[pa];
                hold = sr && ws;
                ws = sw || sr;
                if (!adv) begin
                    ba = a[3:0];
                    cnt = 2'h0;
                    sw = !wn && !s1 && s2 && !s3;
                    sr = wn && !s1 && s2 && !s3;
                end else cnt = cnt + 2'h1;
                pa = {ba[3:2], mode ? ba[1:0] ^ cnt : ba[1:0] + cnt};
                pl = bw;
            end
            exp_oe = exp_oe && hold;
        end
    end
    // Two runs: linear then interleaved, each reset, preload, random
    initial begin
        for (int m = 0; m < 2; m++) begin
            i_rst_n <= 1'h0;
            cmd <= 57'h0;
            mode <= m[0];
            repeat (20) @(posedge i_clock);
            i_rst_n <= 1'h1;
            for (int i = 0; i < 1520; i++) begin
                @(posedge i_clock);
                r = lfsr(r);
                if (i < 20) cmd <= {i < 4 ? 7'h0 : 7'h4, 10'h0, i[3:0], r, r[3:0]};
                else cmd <= {r[2:0] == 3'h0, r[4:3], r[8:6] == 3'h7, r[11:9] != 3'h7,
                    r[14:12] == 3'h7, cmd[50] ^ (r[19:15] == 5'h0), r[23:20], 6'h0,
                    r[27:24], lfsr(r), r[31:28]};
            end
            $display("run %0d done", m);
        end
        finish_test();
    end
    // Hang guard
    initial begin
        #(4000 * 40);
        miscompares++;
        finish_test();
    end
endmodule // sync_pipelined_sram_port_test
bind sync_pipelined_sram_port sram_port_props props (.*);
`default_nettype wire
